// >>> dpw_pkg.sv
// Package with timing constants and command codes for the SRAM port host.
`default_nettype none
package dpw_pkg;
  localparam int unsigned CLK_PERIOD_NS = 20;
  // Write cycle time and strobe width in ns.
  localparam int unsigned WRITE_CYCLE_NS = 15;
  localparam int unsigned WRITE_PULSE_NS = 12;
  localparam int unsigned WRITE_ZOFF_NS = 8;
  localparam int unsigned DATA_SETUP_NS = 10;
  localparam int unsigned FLAG_WR_TO_RD_NS = 5;
  // Least times rounded up to whole cycles, at least one.
  function automatic int unsigned dpw_cyc(input int unsigned ns);
    int unsigned c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction
  localparam int unsigned WRITE_CYCLE_CYC = dpw_cyc(WRITE_CYCLE_NS);
  localparam int unsigned WRITE_PULSE_CYC = dpw_cyc(WRITE_PULSE_NS);
  localparam int unsigned WRITE_LONG_CYC =
    dpw_cyc(WRITE_ZOFF_NS + DATA_SETUP_NS);
  localparam int unsigned FLAG_GAP_CYC = dpw_cyc(FLAG_WR_TO_RD_NS);
  // Command codes of the user port.
  typedef enum logic [1:0] {
    DPW_CMD_WRITE,
    DPW_CMD_FLAG_WRITE,
    DPW_CMD_FLAG_READ
  } dpw_cmd_t;
  localparam logic [3:0] CNT_ONE = 4'h1;
endpackage : dpw_pkg
`default_nettype wire

// >>> dpw_host.sv
// Host controller driving the write side of one dual-port SRAM port.
`timescale 1ns/10ps
`default_nettype none
module dpw_host #(
  parameter int unsigned ADDR_W = 19,
  parameter int unsigned DATA_W = 18
) (
  input  wire logic              core_clk,
  input  wire logic              rst_b,
  input  wire logic              req_valid,
  output logic                   req_ready,
  input  wire dpw_pkg::dpw_cmd_t req_cmd,
  input  wire logic [ADDR_W-1:0] req_addr,
  input  wire logic [DATA_W-1:0] req_data,
  input  wire logic [1:0]        req_lanes_n,
  input  wire logic              req_last,
  output logic                   rsp_valid,
  output logic                   rsp_flag,
  output logic [ADDR_W-1:0]      sram_addr,
  output logic [DATA_W-1:0]      sram_dq_out,
  output logic                   sram_dq_oe_n,
  input  wire logic [DATA_W-1:0] sram_dq_in,
  output logic                   chip_select_low_active,
  output logic                   chip_select_high_active,
  output logic                   flag_select_n,
  output logic                   write_strobe_n,
  output logic                   output_enable_n,
  output logic                   upper_byte_enable_n,
  output logic                   lower_byte_enable_n
);
  typedef enum logic [2:0] {
    DPW_IDLE, DPW_WR, DPW_WR_END, DPW_FWR, DPW_GAP, DPW_FRD
  } dpw_state_t;

  dpw_state_t state_q;
  logic [3:0] cnt_q;
  logic       paced_q;
  logic [1:0] rd_sync_q;
  logic       flag_meta_q;
  logic       flag_sync_q;

  localparam logic [3:0] CNT_ONE_L = dpw_pkg::CNT_ONE;

  // Requests are taken only between phases where pins may change safely.
  assign req_ready = (state_q == DPW_IDLE) ||
                     (state_q == DPW_WR && cnt_q == CNT_ONE_L && paced_q);

  function automatic logic [3:0] dpw_len(input int unsigned c);
    return c[3:0];
  endfunction

  wire take = req_valid && req_ready;

  // Sequencer for array writes, paced writes and flag cycles.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= DPW_IDLE;
      cnt_q   <= 4'h0;
      paced_q <= 1'b0;
    end else begin
      if (cnt_q > CNT_ONE_L) begin
        cnt_q <= cnt_q - CNT_ONE_L;
      end
      unique case (state_q)
        DPW_IDLE: begin
          if (take) begin
            paced_q <= !req_last;
            unique case (req_cmd)
              dpw_pkg::DPW_CMD_WRITE: begin
                state_q <= DPW_WR;
                cnt_q <= dpw_len(dpw_pkg::WRITE_CYCLE_CYC);
              end
              dpw_pkg::DPW_CMD_FLAG_WRITE: begin
                state_q <= DPW_FWR;
                cnt_q <= dpw_len(dpw_pkg::WRITE_PULSE_CYC);
              end
              default: begin
                state_q <= DPW_FRD;
                cnt_q <= dpw_len(dpw_pkg::WRITE_CYCLE_CYC);
              end
            endcase
          end
        end
        DPW_WR: begin
          if (cnt_q == CNT_ONE_L) begin
            if (take && req_cmd == dpw_pkg::DPW_CMD_WRITE) begin
              // Address change closes this write, strobe stays low.
              cnt_q   <= dpw_len(dpw_pkg::WRITE_CYCLE_CYC);
              paced_q <= !req_last;
            end else if (!paced_q) begin
              state_q <= DPW_WR_END; // Strobe rises first, address held.
            end
          end
        end
        DPW_WR_END: state_q <= DPW_IDLE;
        DPW_FWR: if (cnt_q == CNT_ONE_L) begin
          state_q <= DPW_GAP;
          cnt_q <= dpw_len(dpw_pkg::FLAG_GAP_CYC);
        end
        DPW_GAP: if (cnt_q == CNT_ONE_L) state_q <= DPW_IDLE;
        DPW_FRD: if (cnt_q == CNT_ONE_L) state_q <= DPW_IDLE;
        default: state_q <= DPW_IDLE;
      endcase
    end
  end

  // Address, data and lanes are registered so all bits move at one edge.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sram_addr           <= '0;
      sram_dq_out         <= '0;
      upper_byte_enable_n <= 1'b1;
      lower_byte_enable_n <= 1'b1;
    end else if (take) begin
      sram_addr           <= req_addr;
      sram_dq_out         <= req_data;
      upper_byte_enable_n <= req_lanes_n[1];
      lower_byte_enable_n <= req_lanes_n[0];
    end
  end

  wire array_wr = (state_q == DPW_WR);
  wire flag_cyc = (state_q == DPW_FWR) || (state_q == DPW_FRD);

  // Selects are decoded from state and the request being taken; array and flag never overlap.
  // Output enable is kept off during writes, so no stretch is needed.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      chip_select_low_active  <= 1'b1;
      chip_select_high_active <= 1'b0;
      flag_select_n           <= 1'b1;
      write_strobe_n          <= 1'b1;
      output_enable_n         <= 1'b1;
      sram_dq_oe_n            <= 1'b1;
    end else begin
      chip_select_low_active  <= !(array_wr || (take && state_q == DPW_IDLE
        && req_cmd == dpw_pkg::DPW_CMD_WRITE)) || flag_cyc;
      chip_select_high_active <= 1'b0;
      flag_select_n           <= 1'b1;
      write_strobe_n          <= 1'b1;
      output_enable_n         <= 1'b1;
      sram_dq_oe_n            <= 1'b1;
      if ((take && req_cmd == dpw_pkg::DPW_CMD_WRITE) ||
          (array_wr && !(cnt_q == CNT_ONE_L && !paced_q && !take))) begin
        chip_select_high_active <= 1'b1;
        write_strobe_n          <= 1'b0;
        sram_dq_oe_n            <= 1'b0;
      end
      if ((take && state_q == DPW_IDLE &&
           req_cmd == dpw_pkg::DPW_CMD_FLAG_WRITE) ||
          (state_q == DPW_FWR && cnt_q != CNT_ONE_L)) begin
        flag_select_n  <= 1'b0; // Strobe and select fall together.
        write_strobe_n <= 1'b0;
        sram_dq_oe_n   <= 1'b0;
      end
      if ((take && state_q == DPW_IDLE &&
           req_cmd == dpw_pkg::DPW_CMD_FLAG_READ) ||
          (state_q == DPW_FRD && cnt_q != CNT_ONE_L)) begin
        flag_select_n   <= 1'b0;
        output_enable_n <= 1'b0; // Our driver stays off here.
      end
    end
  end

  // Read data is a pin input, synchronised before use.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      flag_meta_q <= 1'b1;
      flag_sync_q <= 1'b1;
    end else begin
      flag_meta_q <= sram_dq_in[0];
      flag_sync_q <= flag_meta_q;
    end
  end

  // Response waits two edges so the synchronised flag is settled.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_sync_q <= 2'b00;
      rsp_valid <= 1'b0;
      rsp_flag  <= 1'b1;
    end else begin
      rd_sync_q <= {rd_sync_q[0], state_q == DPW_FRD && cnt_q == CNT_ONE_L};
      rsp_valid <= rd_sync_q[1];
      if (rd_sync_q[1]) begin
        rsp_flag <= flag_sync_q; // A lost contention simply reads one.
      end
    end
  end

  chk_flag_desel: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    !flag_select_n |-> chip_select_low_active && !chip_select_high_active)
    else $error("array selected during flag cycle");
  chk_strobe_sel: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    !write_strobe_n && flag_select_n |-> chip_select_high_active)
    else $error("array strobe without array select");
  chk_no_contend: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    !output_enable_n |-> sram_dq_oe_n)
    else $error("driving data while device outputs");
  chk_addr_hold: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    $changed(sram_addr) && !$past(write_strobe_n) |-> !write_strobe_n)
    else $error("address moved with strobe rising");
  chk_oe_off_wr: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    !write_strobe_n |-> output_enable_n)
    else $error("output enable active in a write");
  chk_dq_in_wr: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    !write_strobe_n |-> !sram_dq_oe_n)
    else $error("data not driven during write");
  chk_one_sel: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    !(chip_select_high_active && !flag_select_n))
    else $error("array and flag selected together");

  // The flag read closes, then the two synchroniser stages and the
  // response register each take one edge before the answer shows.
  sequence dpw_rd_last_s;
    state_q == DPW_FRD && cnt_q == CNT_ONE_L;
  endsequence
  sequence dpw_rsp_s;
    ##3 rsp_valid;
  endsequence
  chk_rsp_time: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    dpw_rd_last_s |-> dpw_rsp_s)
    else $error("flag response late");
endmodule : dpw_host
`default_nettype wire

// >>> dpw_sram_model.sv
// Behavioural model of one SRAM port with its semaphore flag.
`timescale 1ns/10ps
`default_nettype none
module dpw_sram_model (
  input  wire logic        samp_clk,
  input  wire logic        other_hold,
  input  wire logic [18:0] addr,
  input  wire logic [17:0] dq_host,
  output logic      [17:0] dq_dev,
  input  wire logic        chip_select_low_active,
  input  wire logic        chip_select_high_active,
  input  wire logic        flag_select_n,
  input  wire logic        write_strobe_n,
  input  wire logic        output_enable_n,
  input  wire logic        upper_byte_enable_n,
  input  wire logic        lower_byte_enable_n
);
  // Only the low address bits pick a word; the bench stays in 16 words.
  logic [17:0] mem [16];
  logic        flag_q = 1'b1;
  logic [17:0] last_q = 18'h0;
  logic        sel, arr_wr, flg_wr, flg_rd;
  // Decode of the pins; both chip selects and either byte enable are needed for the array.
  assign sel = !chip_select_low_active && chip_select_high_active;
  assign arr_wr = sel && flag_select_n && !write_strobe_n &&
                  !(upper_byte_enable_n && lower_byte_enable_n);
  assign flg_wr = !sel && !flag_select_n && !write_strobe_n;
  assign flg_rd = !sel && !flag_select_n && write_strobe_n &&
                  !output_enable_n;
  // Pins are sampled mid-cycle, where registered host outputs are settled.
  // Each sample during the overlap rewrites the word at the address shown.
  always @(negedge samp_clk) begin
    if (arr_wr) begin
      if (!lower_byte_enable_n) mem[addr[3:0]][8:0] = dq_host[8:0];
      if (!upper_byte_enable_n) mem[addr[3:0]][17:9] = dq_host[17:9];
    end
    // A request made while the far port holds the flag is lost.
    if (flg_wr) flag_q = dq_host[0] | other_hold;
    last_q = dq_dev;
  end
  // Outputs only on a flag read, never in writes; else a moving pattern.
  assign dq_dev = flg_rd ? {18{flag_q}} : ~last_q;
endmodule // dpw_sram_model
`default_nettype wire

// >>> dpw_host_tb.sv
// Self-checking bench for the SRAM port host and its device model.
`timescale 1ns/10ps
`default_nettype none
module dpw_host_tb;
  logic              core_clk = 1'b0;
  logic              rst_b = 1'b0;
  logic              req_valid = 1'b0;
  dpw_pkg::dpw_cmd_t req_cmd = dpw_pkg::DPW_CMD_WRITE;
  logic [18:0]       req_addr = 19'h0;
  logic [17:0]       req_data = 18'h0;
  logic [1:0]        req_lanes_n = 2'h0;
  logic              req_last = 1'b1;
  logic              other_hold = 1'b0;
  logic              req_ready, rsp_valid, rsp_flag, dq_oe_n, we_n, oe_n;
  logic              cs_lo, cs_hi, fsel_n, ub_n, lb_n;
  logic [18:0]       sram_addr;
  logic [17:0]       dq_out, dq_in;
  logic [17:0]       exp_mem [16];
  logic [31:0]       rng = 32'h8cff;
  int                n_fail = 0;
  int                n_checks = 0;
  int                cyc = 0;
  dpw_host uut (.core_clk(core_clk), .rst_b(rst_b), .req_valid(req_valid),
    .req_ready(req_ready), .req_cmd(req_cmd), .req_addr(req_addr),
    .req_data(req_data), .req_lanes_n(req_lanes_n), .req_last(req_last),
    .rsp_valid(rsp_valid), .rsp_flag(rsp_flag), .sram_addr(sram_addr),
    .sram_dq_out(dq_out), .sram_dq_oe_n(dq_oe_n), .sram_dq_in(dq_in),
    .chip_select_low_active(cs_lo), .chip_select_high_active(cs_hi),
    .flag_select_n(fsel_n), .write_strobe_n(we_n), .output_enable_n(oe_n),
    .upper_byte_enable_n(ub_n), .lower_byte_enable_n(lb_n));
  dpw_sram_model sram (.samp_clk(core_clk), .other_hold(other_hold),
    .addr(sram_addr), .dq_host(dq_out), .dq_dev(dq_in),
    .chip_select_low_active(cs_lo), .chip_select_high_active(cs_hi),
    .flag_select_n(fsel_n), .write_strobe_n(we_n), .output_enable_n(oe_n),
    .upper_byte_enable_n(ub_n), .lower_byte_enable_n(lb_n));
  initial begin
    forever #10 core_clk = ~core_clk;
  end
  // Cuts a hang short; the whole run needs well under this.
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [17:0] e,
                     input logic [17:0] g);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  function automatic logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction
  function automatic logic [17:0] merge(input logic [17:0] o,
                                        input logic [17:0] d,
                                        input logic [1:0] l);
    merge = o;
    if (!l[0]) merge[8:0] = d[8:0];
    if (!l[1]) merge[17:9] = d[17:9];
  endfunction
  // Watch the pins each cycle: flag cycles keep the array deselected and
  // the host drives data only while the strobe is low.
  always @(negedge core_clk) begin
    if (rst_b && fsel_n === 1'b0)
      cmp("flag_desel", 18'h0, {17'h0, !cs_lo && cs_hi});
    if (rst_b && dq_oe_n === 1'b0)
      cmp("drive_we", 18'h0, {17'h0, we_n});
  end
  // Holds the request until taken; valid stays up for a following call.
  task automatic send(input dpw_pkg::dpw_cmd_t c, input logic [3:0] a,
                      input logic [17:0] d, input logic [1:0] l,
                      input logic last);
    int w;
    w = 0;
    req_valid = 1'b1;
    req_cmd = c;
    req_addr = {15'h0, a};
    req_data = d;
    req_lanes_n = l;
    req_last = last;
    #1;
    while (req_ready !== 1'b1 && w < 50) begin
      @(negedge core_clk);
      #1;
      w++;
    end
    if (w == 50) n_fail++;
    @(negedge core_clk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [1:0] l, input logic last);
    logic [31:0] r;
    r = xs();
    exp_mem[a] = merge(exp_mem[a], r[17:0], l);
    send(dpw_pkg::DPW_CMD_WRITE, a, r[17:0], l, last);
  endtask
  task automatic flag_try(input logic v, input logic hold, input logic ev);
    int w;
    w = 0;
    other_hold = hold;
    send(dpw_pkg::DPW_CMD_FLAG_WRITE, 4'h0, {17'h0, v}, 2'h0, 1'b1);
    req_valid = 1'b0;
    @(negedge core_clk);
    send(dpw_pkg::DPW_CMD_FLAG_READ, 4'h0, 18'h0, 2'h0, 1'b1);
    req_valid = 1'b0;
    while (rsp_valid !== 1'b1 && w < 20) begin
      @(negedge core_clk);
      w++;
    end
    cmp("rsp_valid", 18'h1, {17'h0, rsp_valid});
    cmp("rsp_flag", {17'h0, ev}, {17'h0, rsp_flag});
  endtask
  initial begin
    repeat (16) @(negedge core_clk);
    rst_b = 1'b1;
    for (int i = 0; i < 16; i++) wr(i[3:0], 2'h0, 1'b1);
    for (int i = 0; i < 24; i++) begin
      wr(4'(xs()), 2'(xs()), 1'b1);
    end
    for (int b = 0; b < 6; b++) begin
      for (int j = 0; j < 4; j++) begin
        wr(4'(xs()), 2'(xs()), j == 3);
      end
    end
    req_valid = 1'b0;
    repeat (4) @(negedge core_clk);
    for (int i = 0; i < 16; i++) begin
      cmp("mem", exp_mem[i], sram.mem[i]);
    end
    flag_try(1'b0, 1'b0, 1'b0);
    flag_try(1'b1, 1'b0, 1'b1);
    flag_try(1'b0, 1'b1, 1'b1);
    // A reset in mid-run must put both chip selects, the flag select, the write strobe and the data driver back to idle.
    rst_b = 1'b0;
    repeat (2) @(negedge core_clk);
    cmp("rst_pins", 18'h17, {13'h0, cs_lo, cs_hi, we_n, fsel_n, dq_oe_n});
    rst_b = 1'b1;
    wr(4'h5, 2'h0, 1'b1);
    req_valid = 1'b0;
    repeat (4) @(negedge core_clk);
    cmp("mem_after_rst", exp_mem[5], sram.mem[5]);
    report_and_stop();
  end
endmodule // dpw_host_tb
`default_nettype wire
